/* hdl/azr_pkg.sv */
// Constants, register map and carrier types of the axis zero-return block.
// Assumes a 40 MHz system clock and a host port with one-cycle strobes.
package azr_pkg;

    // Clock and timing
    localparam int CLK_FREQ_MHZ = 40;
    localparam int FILT_TIME_NS = 4000;
    localparam int FILT_CYC = (FILT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int FILT_W = 8;

    // Host port
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_ENV_ONE = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_ENV_TWO = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_ENV_THREE = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_EXT_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_SUB_STATUS = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_MODE = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h18;

    // Reset values
    localparam logic [31:0] ENV_RESET = 32'h0000_0000;
    localparam logic [6:0] MODE_RESET = 7'h00;

    // Environment one fields
    localparam int ENV1_ORG_POL = 0;
    localparam int ENV1_LIM_DECEL = 3;
    localparam int ENV1_AUTO_DEV_CLR = 11;
    localparam int ENV1_FILTER = 26;
    // Environment two fields
    localparam int ENV2_IDX_RISE = 23;
    // Environment three fields
    localparam int ENV3_METHOD_LSB = 0;
    localparam int ENV3_IDX_CNT_LSB = 4;
    localparam int ENV3_CLR_LSB = 20;
    localparam logic [3:0] METHOD_INDEX_FIRST = 4'h2;

    // Status fields
    localparam int EXT_BUSY = 0;
    localparam int EXT_LIM_STOP = 1;
    localparam int EXT_DECEL = 2;
    localparam int EXT_INDEX = 10;
    localparam int SUB_LIM_POS = 12;
    localparam int SUB_LIM_NEG = 13;
    localparam int SUB_ORIGIN = 14;

    // Command word fields
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;

    // Operation mode codes
    localparam logic [6:0] MODE_ZR_POS = 7'h10;
    localparam logic [6:0] MODE_ZR_NEG = 7'h18;

    typedef enum logic [2:0] {
        AZR_IDLE = 3'b001,
        AZR_FEED = 3'b010,
        AZR_DECEL = 3'b100
    } azr_state_e;

    typedef struct packed {
        logic limit_polarity;
        logic end_limit_neg;
        logic end_limit_pos;
        logic encoder_index;
        logic origin_switch;
    } azr_pins_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } azr_bus_s;

endpackage : azr_pkg

/* hdl/azr_axis_zero_return.sv */
// Axis zero-return logic: switch conditioning, index counting, feed control.
// Assumes switch pins are asynchronous and the host strobes never overlap.
//
// Overview of operation
// - Origin input active low when polarity bit is 0, active high when 1.
// - Sub status bit 14 shows the origin switch state, 1 meaning on.
// - Index pulses counted on falling edges, or rising edges when bit 23 set.
// - In index methods, zero return completes when index count reaches programmed field plus one.
// - Extension status bit 10 shows the live index input state.
// - End limits active high when polarity pin low, active low when high.
// - Limit in feed direction stops pulses at once, or decelerates if bit 3.
// - Sub status bits 12 and 13 show positive and negative limit states.
// - With filter bit 26 set, limit and origin pulses under 4 us ignored.
// - After start in zero-return mode, feed pulses continue until completion, a stop command or a limit stop.
// - Mode 10h returns in positive direction, 18h in negative direction.
// - Completion clears selected counters and may pulse deviation clear.
// - Counter clear at completion only where environment three enables it.
// - Deviation clear pulse only when auto output enabled in environment one.
// - Bits 20 to 23 select command, mechanical, deviation, general counters.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module azr_axis_zero_return #(
    parameter int FEED_DIV = 16,
    parameter int DECEL_PULSES = 8,
    parameter int DEV_CLR_CYC = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input azr_pkg::azr_bus_s bus_i,
    input azr_pkg::azr_pins_s pins_i,
    output logic [31:0] rdata_o,
    output logic feed_pulse_o,
    output logic feed_dir_o,
    output logic busy_o,
    output logic deviation_clear_out_o,
    output logic [3:0] counter_clear_o
);
    import azr_pkg::*;

    function automatic logic hit(input azr_bus_s b, input logic [ADDR_W-1:0] a);
        hit = b.addr == a;
    endfunction : hit

    azr_pins_s sync_a;
    azr_pins_s sync_b;
    logic [31:0] env_one;
    logic [31:0] env_two;
    logic [31:0] env_three;
    logic [6:0] operation_mode_code;
    logic [2:0] act;
    logic [2:0] flt;
    logic [FILT_W-1:0] flt_cnt [3];
    logic idx_prev;
    logic idx_edge;
    logic [3:0] idx_cnt;
    logic org_prev;
    logic org_seen;
    logic zr_done;
    logic lim_hit;
    logic lim_stop;
    logic start_cmd;
    logic stop_cmd;
    logic [15:0] div_cnt;
    logic [15:0] decel_left;
    logic [7:0] dev_cnt;
    logic [31:0] ext_status;
    logic [15:0] sub_status;
    azr_state_e state;
    azr_state_e next_state;

    // Two-flop input synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pins_i;
            sync_b <= sync_a;
        end
    end

    // Polarity: origin by register bit, limits by the polarity pin
    always_comb begin
        act[0] = sync_b.origin_switch ~^ env_one[ENV1_ORG_POL];
        act[1] = sync_b.end_limit_pos ^ sync_b.limit_polarity;
        act[2] = sync_b.end_limit_neg ^ sync_b.limit_polarity;
    end

    // Glitch filter: a change must persist for the filter time
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flt <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                flt_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!env_one[ENV1_FILTER] || act[i] == flt[i]) begin
                    flt[i] <= act[i];
                    flt_cnt[i] <= '0;
                end else if (flt_cnt[i] == FILT_W'(FILT_CYC - 1)) begin
                    flt[i] <= act[i];
                    flt_cnt[i] <= '0;
                end else begin
                    flt_cnt[i] <= flt_cnt[i] + FILT_W'(1);
                end
            end
        end
    end

    // Index edge select
    always_comb begin
        if (env_two[ENV2_IDX_RISE]) begin
            idx_edge = sync_b.encoder_index & ~idx_prev;
        end else begin
            idx_edge = ~sync_b.encoder_index & idx_prev;
        end
    end

    // Completion: origin-only methods, or origin then index count
    always_comb begin
        if (env_three[ENV3_METHOD_LSB +: 4] < METHOD_INDEX_FIRST) begin
            zr_done = flt[0] & ~org_prev;
        end else begin
            zr_done = org_seen & idx_edge
                & (idx_cnt == env_three[ENV3_IDX_CNT_LSB +: 4]);
        end
        lim_hit = feed_dir_o ? flt[2] : flt[1];
        start_cmd = bus_i.wr && hit(bus_i, OFS_COMMAND)
            && bus_i.wdata[CMD_START]
            && (operation_mode_code == MODE_ZR_POS
            || operation_mode_code == MODE_ZR_NEG);
        stop_cmd = bus_i.wr && hit(bus_i, OFS_COMMAND)
            && bus_i.wdata[CMD_STOP];
    end

    // Index counter and origin tracking
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idx_prev <= 1'b0;
            org_prev <= 1'b0;
            org_seen <= 1'b0;
            idx_cnt <= 4'h0;
        end else begin
            idx_prev <= sync_b.encoder_index;
            org_prev <= flt[0];
            if (state != AZR_FEED) begin
                org_seen <= 1'b0;
                idx_cnt <= 4'h0;
            end else begin
                if (flt[0]) begin
                    org_seen <= 1'b1;
                end
                if (org_seen && idx_edge) begin
                    idx_cnt <= idx_cnt + 4'h1;
                end
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            env_one <= ENV_RESET;
            env_two <= ENV_RESET;
            env_three <= ENV_RESET;
            operation_mode_code <= MODE_RESET;
        end else if (bus_i.wr) begin
            if (hit(bus_i, OFS_ENV_ONE)) begin
                env_one <= bus_i.wdata;
            end
            if (hit(bus_i, OFS_ENV_TWO)) begin
                env_two <= bus_i.wdata;
            end
            if (hit(bus_i, OFS_ENV_THREE)) begin
                env_three <= bus_i.wdata;
            end
            if (hit(bus_i, OFS_MODE)) begin
                operation_mode_code <= bus_i.wdata[6:0];
            end
        end
    end

    // Feed state machine
    always_comb begin
        next_state = state;
        unique case (state)
            AZR_IDLE: begin
                if (start_cmd) begin
                    next_state = AZR_FEED;
                end
            end
            AZR_FEED: begin
                if (stop_cmd || zr_done) begin
                    next_state = AZR_IDLE;
                end else if (lim_hit) begin
                    next_state = env_one[ENV1_LIM_DECEL] ? AZR_DECEL
                        : AZR_IDLE;
                end
            end
            AZR_DECEL: begin
                if (stop_cmd || decel_left == 16'h0000) begin
                    next_state = AZR_IDLE;
                end
            end
            default: next_state = AZR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= AZR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Direction, pulse divider and deceleration tail
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            feed_dir_o <= 1'b0;
            feed_pulse_o <= 1'b0;
            div_cnt <= 16'h0000;
            decel_left <= 16'h0000;
            busy_o <= 1'b0;
        end else begin
            busy_o <= next_state != AZR_IDLE;
            if (state == AZR_IDLE && start_cmd) begin
                feed_dir_o <= operation_mode_code == MODE_ZR_NEG;
            end
            if (next_state == AZR_IDLE) begin
                div_cnt <= 16'h0000;
                feed_pulse_o <= 1'b0;
            end else begin
                feed_pulse_o <= div_cnt == 16'h0000;
                div_cnt <= (div_cnt == 16'(FEED_DIV - 1)) ? 16'h0000
                    : div_cnt + 16'h0001;
            end
            if (state == AZR_FEED) begin
                decel_left <= 16'(DECEL_PULSES);
            end else if (state == AZR_DECEL && feed_pulse_o
                && decel_left != 16'h0000) begin
                decel_left <= decel_left - 16'h0001;
            end
        end
    end

    // Completion actions and limit stop flag
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            counter_clear_o <= 4'h0;
            deviation_clear_out_o <= 1'b0;
            dev_cnt <= 8'h00;
            lim_stop <= 1'b0;
        end else begin
            counter_clear_o <= 4'h0;
            if (state == AZR_FEED && zr_done) begin
                counter_clear_o <= env_three[ENV3_CLR_LSB +: 4];
            end
            if (state == AZR_FEED && zr_done && env_one[ENV1_AUTO_DEV_CLR]) begin
                dev_cnt <= 8'(DEV_CLR_CYC - 1);
                deviation_clear_out_o <= 1'b1;
            end else if (dev_cnt != 8'h00) begin
                dev_cnt <= dev_cnt - 8'h01;
            end else begin
                deviation_clear_out_o <= 1'b0;
            end
            if (state == AZR_FEED && !zr_done && !stop_cmd && lim_hit) begin
                lim_stop <= 1'b1;
            end else if (state == AZR_IDLE && start_cmd) begin
                lim_stop <= 1'b0;
            end
        end
    end

    // Status words
    always_comb begin
        ext_status = 32'h0000_0000;
        ext_status[EXT_BUSY] = state != AZR_IDLE;
        ext_status[EXT_LIM_STOP] = lim_stop;
        ext_status[EXT_DECEL] = state == AZR_DECEL;
        ext_status[EXT_INDEX] = sync_b.encoder_index;
        sub_status = 16'h0000;
        sub_status[SUB_LIM_POS] = flt[1];
        sub_status[SUB_LIM_NEG] = flt[2];
        sub_status[SUB_ORIGIN] = flt[0];
    end

    // Read port, data valid one cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !bus_i.rd) begin
            rdata_o <= 32'h0000_0000;
        end else if (hit(bus_i, OFS_EXT_STATUS)) begin
            rdata_o <= ext_status;
        end else if (hit(bus_i, OFS_SUB_STATUS)) begin
            rdata_o <= {16'h0000, sub_status};
        end else if (hit(bus_i, OFS_MODE)) begin
            rdata_o <= {25'h000_0000, operation_mode_code};
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_origin_armed;
        state == AZR_FEED && org_seen;
    endsequence

    sequence s_last_index;
        idx_edge && env_three[ENV3_METHOD_LSB +: 4] >= METHOD_INDEX_FIRST
            && idx_cnt == env_three[ENV3_IDX_CNT_LSB +: 4];
    endsequence

    chk_index_done: assert property (
        (s_origin_armed and s_last_index) |=> state == AZR_IDLE)
        else $error("index count reached but feed did not end");

    chk_org_status: assert property (
        bus_i.rd && hit(bus_i, OFS_SUB_STATUS) |=> rdata_o[14] == $past(flt[0]))
        else $error("origin status bit wrong");

    chk_index_status: assert property (
        bus_i.rd && hit(bus_i, OFS_EXT_STATUS)
        |=> rdata_o[10] == $past(sync_b.encoder_index))
        else $error("index status bit wrong");

    chk_limit_status: assert property (
        bus_i.rd && hit(bus_i, OFS_SUB_STATUS)
        |=> rdata_o[13:12] == $past({flt[2], flt[1]}))
        else $error("limit status bits wrong");

    chk_org_polarity: assert property (
        !env_one[ENV1_FILTER] && $stable(env_one)
        |=> flt[0] == $past(sync_b.origin_switch ~^ env_one[ENV1_ORG_POL]))
        else $error("origin polarity not applied");

    chk_filter_short: assert property (
        env_one[ENV1_FILTER] && $past(env_one[ENV1_FILTER])
        && flt[0] != $past(flt[0])
        |-> $past(flt_cnt[0]) == FILT_W'(FILT_CYC - 1))
        else $error("origin accepted before filter time");

    chk_imm_stop: assert property (
        state == AZR_FEED && lim_hit && !zr_done && !stop_cmd
        && !env_one[ENV1_LIM_DECEL] |=> state == AZR_IDLE ##1 !feed_pulse_o[*4])
        else $error("limit did not stop pulses at once");

    chk_dir_mode: assert property (
        state == AZR_IDLE && start_cmd
        |=> state == AZR_FEED
        && feed_dir_o == ($past(operation_mode_code) == MODE_ZR_NEG))
        else $error("feed direction does not follow mode");

    chk_clear_gate: assert property (
        state == AZR_FEED && zr_done
        |=> counter_clear_o == $past(env_three[ENV3_CLR_LSB +: 4]))
        else $error("counter clear not gated by enables");

    chk_dev_clear_gate: assert property (
        state == AZR_FEED && zr_done
        |=> deviation_clear_out_o == $past(env_one[ENV1_AUTO_DEV_CLR]))
        else $error("deviation clear not gated by enable");

endmodule : azr_axis_zero_return

/* verif/azr_switch_model.sv */
// Switch and index sensor model on the pin side of the zero-return block.
// Assumes the bench gives logical on states and the chosen polarities.
`timescale 1ns/1ps

module azr_switch_model (
    input wire logic org_on_i,
    input wire logic org_pol_i,
    input wire logic idx_lvl_i,
    input wire logic lim_pos_on_i,
    input wire logic lim_neg_on_i,
    input wire logic lim_pol_i,
    output azr_pkg::azr_pins_s pins_o
);
    import azr_pkg::*;
    // One driver for the whole pin group, fields in struct order
    // Polarity pin low: limits drive high when on
    // Origin pin low when on, unless positive polarity chosen
    assign pins_o = {lim_pol_i,
        lim_pol_i ? ~lim_neg_on_i : lim_neg_on_i,
        lim_pol_i ? ~lim_pos_on_i : lim_pos_on_i,
        idx_lvl_i,
        org_pol_i ? org_on_i : ~org_on_i};
endmodule : azr_switch_model

/* verif/azr_axis_zero_return_tb_top.sv */
// Self-checking bench of the axis zero-return block.
// Assumes the switch model on the pins and a one-cycle host port.
`timescale 1ns/1ps

module azr_axis_zero_return_tb_top;
    import azr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    azr_bus_s bus = '0;
    azr_pins_s pins;
    logic [31:0] rdata_o;
    logic feed_pulse_o;
    logic feed_dir_o;
    logic busy_o;
    logic dev_clr;
    logic [3:0] cnt_clr;
    logic org_on = 1'b0;
    logic org_pol = 1'b0;
    logic idx = 1'b0;
    logic lim_pos = 1'b0;
    logic lim_neg = 1'b0;
    logic lim_pol = 1'b0;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int pulses = 0;
    int dev_cnt = 0;
    logic [3:0] clr_seen = 4'h0;
    logic last_dir = 1'b0;
    logic [31:0] d;

    azr_axis_zero_return i_dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus_i(bus),
        .pins_i(pins),
        .rdata_o(rdata_o),
        .feed_pulse_o(feed_pulse_o),
        .feed_dir_o(feed_dir_o),
        .busy_o(busy_o),
        .deviation_clear_out_o(dev_clr),
        .counter_clear_o(cnt_clr)
    );

    azr_switch_model i_sw (
        .org_on_i(org_on),
        .org_pol_i(org_pol),
        .idx_lvl_i(idx),
        .lim_pos_on_i(lim_pos),
        .lim_neg_on_i(lim_neg),
        .lim_pol_i(lim_pol),
        .pins_o(pins)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Event monitor and hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        // Counters restart at every command write
        if (bus.wr && bus.addr == OFS_COMMAND) begin
            pulses <= 0;
            dev_cnt <= 0;
            clr_seen <= 4'h0;
        end else begin
            if (feed_pulse_o === 1'b1) begin
                pulses <= pulses + 1;
                last_dir <= feed_dir_o;
            end
            if (dev_clr === 1'b1) begin
                dev_cnt <= dev_cnt + 1;
            end
            if (cnt_clr !== 4'h0) begin
                clr_seen <= cnt_clr;
            end
        end
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    task automatic wt(input int n);
        bus.wr <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : wt

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk_i);
    endtask : wr

    // Strobe lowered by the next wt or rd, so writes may run back to back
    task automatic rd(input logic [4:0] a);
        bus.addr <= a;
        bus.wr <= 1'b0;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask : rd

    task automatic start(input logic [31:0] e1, e3, input logic [6:0] m);
        wr(OFS_ENV_ONE, e1);
        wr(OFS_ENV_THREE, e3);
        wr(OFS_MODE, {25'h0, m});
        wr(OFS_COMMAND, 32'h1);
        wt(40);
    endtask : start

    task automatic t_status();
        for (int i = 0; i < 4; i++) begin
            org_pol <= i[1];
            org_on <= i[0];
            wr(OFS_ENV_ONE, {31'h0, i[1]});
            wt(8);
            rd(OFS_SUB_STATUS);
            chk(d & 32'h4000, {17'h0, i[0], 14'h0});
        end
        org_on <= 1'b0;
        lim_pos <= 1'b1;
        wt(8);
        rd(OFS_SUB_STATUS);
        chk(d & 32'h3000, 32'h1000);
        lim_pol <= 1'b1;
        lim_pos <= 1'b0;
        lim_neg <= 1'b1;
        wt(8);
        rd(OFS_SUB_STATUS);
        chk(d & 32'h3000, 32'h2000);
        lim_neg <= 1'b0;
        lim_pol <= 1'b0;
        idx <= 1'b1;
        wt(8);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h400, 32'h400);
        idx <= 1'b0;
        wt(8);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h400, 32'h0);
        rd(5'h1C);
        chk(d, 32'h0);
        rd(OFS_ENV_ONE);
        chk(d, 32'h0);
    endtask : t_status

    task automatic t_zr_pos();
        start(32'h0000_0801, 32'h0050_0000, MODE_ZR_POS);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h1);
        chk({31'h0, busy_o}, 32'h1);
        chk({31'h0, pulses > 1}, 32'h1);
        chk({31'h0, last_dir}, 32'h0);
        org_on <= 1'b1;
        wt(16);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h0);
        chk({31'h0, busy_o}, 32'h0);
        chk({28'h0, clr_seen}, 32'h5);
        chk(dev_cnt, 32'h4);
        org_on <= 1'b0;
    endtask : t_zr_pos

    task automatic t_zr_idx();
        wr(OFS_ENV_TWO, 32'h0080_0000);
        start(32'h1, 32'h00A0_0012, MODE_ZR_NEG);
        org_on <= 1'b1;
        wt(16);
        idx <= 1'b1;
        wt(8);
        idx <= 1'b0;
        wt(8);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h1);
        idx <= 1'b1;
        wt(8);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h0);
        chk({28'h0, clr_seen}, 32'hA);
        chk(dev_cnt, 32'h0);
        chk({31'h0, last_dir}, 32'h1);
        idx <= 1'b0;
        org_on <= 1'b0;
        wr(OFS_ENV_TWO, 32'h0);
        start(32'h1, 32'h0010_0002, MODE_ZR_POS);
        org_on <= 1'b1;
        idx <= 1'b1;
        wt(16);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h1);
        idx <= 1'b0;
        wt(8);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h0);
        chk({28'h0, clr_seen}, 32'h1);
        org_on <= 1'b0;
    endtask : t_zr_idx

    task automatic t_limit();
        start(32'h1, 32'h0, MODE_ZR_POS);
        lim_neg <= 1'b1;
        wt(16);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h3, 32'h1);
        lim_pos <= 1'b1;
        wt(8);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h3, 32'h2);
        lim_pos <= 1'b0;
        lim_neg <= 1'b0;
        wt(8);
        start(32'h9, 32'h0, MODE_ZR_POS);
        lim_pos <= 1'b1;
        wt(16);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h5, 32'h5);
        wt(200);
        rd(OFS_EXT_STATUS);
        chk(d & 32'h1, 32'h0);
        lim_pos <= 1'b0;
    endtask : t_limit

    task automatic t_filter();
        wr(OFS_ENV_ONE, 32'h0400_0001);
        org_on <= 1'b1;
        wt(100);
        rd(OFS_SUB_STATUS);
        chk(d & 32'h4000, 32'h0);
        org_on <= 1'b0;
        wt(20);
        org_on <= 1'b1;
        wt(250);
        rd(OFS_SUB_STATUS);
        chk(d & 32'h4000, 32'h4000);
        org_on <= 1'b0;
        lim_pos <= 1'b1;
        wt(100);
        rd(OFS_SUB_STATUS);
        chk(d & 32'h1000, 32'h0);
        wt(100);
        rd(OFS_SUB_STATUS);
        chk(d & 32'h1000, 32'h1000);
        lim_pos <= 1'b0;
    endtask : t_filter

    task automatic final_report();
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        wt(10);
        rst_n_i <= 1'b1;
        wt(2);
        t_status();
        t_zr_pos();
        t_zr_idx();
        t_limit();
        t_filter();
        final_report();
    end
endmodule : azr_axis_zero_return_tb_top
